// File: sim/cfg_host_model.sv
// Purpose: behavioural configuring host on the byte register port
// Assumes: strobes are taken on the rising edge, ready follows
// Notes:   the testbench drives it through its access task
`timescale 1ns/100ps
`default_nettype none

module cfg_host_model
(
    // clock
    input  wire logic       clk,
    // register port
    input  wire logic       ready,
    input  wire logic [7:0] rdata,
    output logic            wr_en,
    output logic            rd_en,
    output logic [7:0]      addr,
    output logic [7:0]      wdata
);
    // idle bus at time zero
    initial
    begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
    end

    // one strobe edge, then a bounded wait for ready; released lines
    // are inverted so a stale address or byte never looks valid
    task automatic access(input logic w, input logic [7:0] a, d,
                          output logic [7:0] q);
        int n;
        @(negedge clk);
        wr_en = w;
        rd_en = !w;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = ~a;
        wdata = ~d;
        for (n = 0; n < 4 && ready !== 1'b1; n++)
            @(negedge clk);
        q = rdata;
    endtask
endmodule
`default_nettype wire

// File: sim/hub_cfg_monitor.sv
// Purpose: port-level checker for the hub configuration register bank
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to every instance of the top module
`timescale 1ns/100ps
`default_nettype none

module hub_cfg_monitor
(
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic NRST,
    // register port
    input wire logic REG_WRITE,
    input wire logic REG_READ,
    input wire logic REG_READY,
    // descriptor port
    input wire logic DESC_REQ,
    input wire logic DESC_BUSY,
    input wire logic DESC_VALID,
    input wire logic DESC_LAST,
    input wire logic DESC_NONE,
    // power and connect
    input wire logic CHARGING_MODE_CHANGE,
    input wire logic DOWNSTREAM_POWER_SWITCH_ENABLE,
    input wire logic UPSTREAM_CONNECT_ALLOW,
    input wire logic CONFIGURATION_IN_PROGRESS
);
    wire pwr = DOWNSTREAM_POWER_SWITCH_ENABLE;
    wire cfg = CONFIGURATION_IN_PROGRESS;

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!NRST);

    // every taken access is answered on the next edge
    a_access_answered: assert property (
        (REG_WRITE || REG_READ) |=> REG_READY)
        else $error("register access not answered");
    // a settled flag must keep the upstream port off
    a_upstream_held: assert property (
        cfg && $past(cfg) |-> !UPSTREAM_CONNECT_ALLOW)
        else $error("upstream allowed while configuring");
    // a taken request either streams or reports no string
    a_desc_answer: assert property (
        DESC_REQ && !DESC_BUSY |=> DESC_NONE || DESC_BUSY)
        else $error("descriptor request not answered");
    a_none_alone: assert property (
        DESC_NONE |-> !DESC_VALID && !DESC_BUSY)
        else $error("no-string reply mixed with data");
    a_last_valid: assert property (DESC_LAST |-> DESC_VALID)
        else $error("last flag without a byte");
    a_valid_busy: assert property (
        DESC_VALID && !DESC_LAST |-> DESC_BUSY)
        else $error("byte outside a descriptor");
    // busy may only drop together with the final byte
    a_busy_ends: assert property ($fell(DESC_BUSY) |-> DESC_LAST)
        else $error("descriptor cut short");
    a_charge_drops: assert property (
        $rose(CHARGING_MODE_CHANGE) |=> !pwr)
        else $error("power kept on at mode change");
    // sized for the shortened step used in simulation
    a_power_returns: assert property ($fell(pwr) |-> ##[1:1000] pwr)
        else $error("power never re-enabled");

    c_desc_last: cover property (DESC_LAST);
    c_desc_none: cover property (DESC_NONE);
    c_cfg_done: cover property ($fell(cfg));
endmodule

bind hub_string_and_config_regs hub_cfg_monitor mon_u
(
    .CORE_CLK, .NRST, .REG_WRITE, .REG_READ, .REG_READY,
    .DESC_REQ, .DESC_BUSY, .DESC_VALID, .DESC_LAST, .DESC_NONE,
    .CHARGING_MODE_CHANGE, .DOWNSTREAM_POWER_SWITCH_ENABLE,
    .UPSTREAM_CONNECT_ALLOW, .CONFIGURATION_IN_PROGRESS
);
`default_nettype wire

// File: sim/tb.sv
// Purpose: self-checking bench for the hub configuration register bank
// Assumes: power step shortened to 10 cycles
// Notes:   register traffic goes through the host model
`timescale 1ns/100ps
`default_nettype none
`include "hub_cfg_defines.svh"

module tb;
    import hub_cfg_pkg::*;
    localparam int STEP = 10;
    logic CORE_CLK = 1'b0;
    logic NRST, SMBUS_MODE, CONFIG_MODE_ENTER, I2C_MODE_EXIT;
    logic REG_WRITE, REG_READ, REG_READY, CHARGING_MODE_CHANGE;
    logic [7:0] REG_ADDR, DESC_INDEX;
    cfg_byte_t REG_WDATA, REG_RDATA, DESC_DATA;
    delay_sel_t FUSED_POWER_ON_DELAY;
    logic [3:0] LINK_STATUS_IN, STATUS_OUT;
    logic DESC_REQ, DESC_BUSY, DESC_VALID, DESC_LAST, DESC_NONE;
    logic DOWNSTREAM_POWER_SWITCH_ENABLE, PLL_SPREAD_DISABLE;
    logic UPSTREAM_CONNECT_ALLOW, CONFIGURATION_IN_PROGRESS;
    logic [7:0] q;
    int n_errors = 0;
    int checks = 0;

    hub_string_and_config_regs #(.STEP_CYCLES(STEP)) dut_u (
        .CORE_CLK, .NRST, .REG_WRITE, .REG_READ, .REG_ADDR, .REG_WDATA,
        .REG_RDATA, .REG_READY, .SMBUS_MODE, .CONFIG_MODE_ENTER,
        .I2C_MODE_EXIT, .FUSED_POWER_ON_DELAY, .CHARGING_MODE_CHANGE,
        .LINK_STATUS_IN, .DESC_REQ, .DESC_INDEX, .DESC_BUSY, .DESC_VALID,
        .DESC_DATA, .DESC_LAST, .DESC_NONE, .STATUS_OUT,
        .DOWNSTREAM_POWER_SWITCH_ENABLE, .PLL_SPREAD_DISABLE,
        .UPSTREAM_CONNECT_ALLOW, .CONFIGURATION_IN_PROGRESS);

    cfg_host_model host_u (.clk(CORE_CLK), .ready(REG_READY),
        .rdata(REG_RDATA), .wr_en(REG_WRITE), .rd_en(REG_READ),
        .addr(REG_ADDR), .wdata(REG_WDATA));

    // 200 MHz core clock
    always #2.5 CORE_CLK = ~CORE_CLK;

    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, d);
        logic [7:0] dummy;
        host_u.access(1'b1, a, d, dummy);
        check("write ready", 8'(REG_READY), 8'h01);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        host_u.access(1'b0, a, 8'h00, d);
        check("read ready", 8'(REG_READY), 8'h01);
    endtask

    // utf-16 text: one letter per even byte, zero high bytes
    function automatic logic [7:0] code(logic [7:0] b, int k);
        return k[0] ? 8'h00 : b + 8'(k / 2);
    endfunction

    task automatic wait_n(int n);
        repeat (n) @(negedge CORE_CLK);
    endtask

    // ask for a descriptor and compare bytes and count
    task automatic desc(input logic [7:0] idx, b, input int len);
        int got;
        got = 0;
        @(negedge CORE_CLK);
        DESC_INDEX = idx;
        DESC_REQ = 1'b1;
        @(negedge CORE_CLK);
        DESC_REQ = 1'b0;
        DESC_INDEX = ~idx;
        for (int n = 0; n < 80; n++)
        begin
            if (DESC_VALID === 1'b1)
            begin
                check("desc byte", DESC_DATA, code(b, got));
                got++;
            end
            if (DESC_LAST === 1'b1 || DESC_NONE === 1'b1)
                break;
            @(negedge CORE_CLK);
        end
        check("desc count", 8'(got), 8'(len));
    endtask

    // count off cycles: two pipeline cycles plus the selected delay
    task automatic power_gap(input int exp);
        int n;
        n = 0;
        @(negedge CORE_CLK);
        CHARGING_MODE_CHANGE = 1'b1;
        @(negedge CORE_CLK);
        CHARGING_MODE_CHANGE = 1'b0;
        for (int k = 0; k < 100; k++)
        begin
            n += (DOWNSTREAM_POWER_SWITCH_ENABLE === 1'b0);
            @(negedge CORE_CLK);
        end
        check("power gap", 8'(n), 8'(exp + 2));
    endtask

    // watchdog: the tests need a few hundred cycles
    initial
    begin
        repeat (20000) @(posedge CORE_CLK);
        n_errors++;
        give_verdict();
    end

    initial
    begin
        NRST = 1'b0;
        {SMBUS_MODE, CONFIG_MODE_ENTER, I2C_MODE_EXIT} = 3'h0;
        {CHARGING_MODE_CHANGE, DESC_REQ} = 2'h0;
        FUSED_POWER_ON_DELAY = 3'h0;
        LINK_STATUS_IN = 4'ha;
        DESC_INDEX = 8'h00;
        wait_n(5);
        NRST = 1'b1;
        wait_n(2);
        rd(`FEATURE_CFG_ADDR, q);
        check("feature reset", q, `FEAT_RESET);
        rd(`MGMT_STATUS_ADDR, q);
        check("status reset", q, 8'h01);
        rd(8'hf4, q);
        check("unmapped", q, 8'h00);
        check("connect held", 8'(UPSTREAM_CONNECT_ALLOW), 8'h00);
        // strings: five bytes each, lengths shorter
        for (int k = 0; k < 5; k++)
        begin
            wr(`MFG_TEXT_BASE + 8'(k), code(8'h41, k));
            wr(`PROD_TEXT_BASE + 8'(k), code(8'h43, k));
        end
        desc(`PROD_DESC_INDEX, 8'h43, 0);
        wr(`MFG_LEN_ADDR, 8'h03);
        wr(`PROD_LEN_ADDR, 8'h02);
        desc(`MFG_DESC_INDEX, 8'h41, 3);
        desc(`PROD_DESC_INDEX, 8'h43, 2);
        rd(`MFG_TEXT_BASE + 8'h02, q);
        check("text readback", q, 8'h42);
        // feature bits
        wr(`FEATURE_CFG_ADDR, 8'h11);
        wait_n(4);
        check("status pins", 8'(STATUS_OUT), 8'h0a);
        check("spread off", 8'(PLL_SPREAD_DISABLE), 8'h01);
        wr(`FEATURE_CFG_ADDR, 8'h04);
        wait_n(2);
        check("status low", 8'(STATUS_OUT), 8'h00);
        check("spread on", 8'(PLL_SPREAD_DISABLE), 8'h00);
        power_gap(2 * STEP);
        FUSED_POWER_ON_DELAY = 3'h1;
        power_gap(STEP);
        FUSED_POWER_ON_DELAY = 3'h0;
        wr(`FEATURE_CFG_ADDR, 8'h00);
        power_gap(0);
        // configuration flag
        wr(`MGMT_STATUS_ADDR, 8'hfc);
        rd(`MGMT_STATUS_ADDR, q);
        check("status bits", q, 8'h01);
        wr(`MGMT_STATUS_ADDR, 8'h01);
        rd(`MGMT_STATUS_ADDR, q);
        check("flag cleared", q, 8'h00);
        wait_n(2);
        check("connect free", 8'(UPSTREAM_CONNECT_ALLOW), 8'h01);
        check("flag pin", 8'(CONFIGURATION_IN_PROGRESS), 8'h00);
        CONFIG_MODE_ENTER = 1'b1;
        wait_n(3);
        CONFIG_MODE_ENTER = 1'b0;
        wait_n(3);
        rd(`MGMT_STATUS_ADDR, q);
        check("flag on entry", q, 8'h01);
        I2C_MODE_EXIT = 1'b1;
        wait_n(3);
        I2C_MODE_EXIT = 1'b0;
        wait_n(3);
        rd(`MGMT_STATUS_ADDR, q);
        check("flag on exit", q, 8'h00);
        // soft reset: refused outside management mode, then taken
        wr(`FEATURE_CFG_ADDR, 8'h11);
        wr(`MGMT_STATUS_ADDR, 8'h02);
        rd(`FEATURE_CFG_ADDR, q);
        check("reset refused", q, 8'h11);
        SMBUS_MODE = 1'b1;
        wait_n(3);
        wr(`MGMT_STATUS_ADDR, 8'h02);
        rd(`FEATURE_CFG_ADDR, q);
        check("feature reloaded", q, `FEAT_RESET);
        rd(`MFG_TEXT_BASE, q);
        check("text reloaded", q, `TEXT_RESET);
        rd(`MGMT_STATUS_ADDR, q);
        check("soft reset done", q, 8'h01);
        desc(`MFG_DESC_INDEX, 8'h41, 0);
        wr(`MGMT_STATUS_ADDR, 8'h01);
        rd(`MGMT_STATUS_ADDR, q);
        check("config ended", q, 8'h00);
        give_verdict();
    end
endmodule
`default_nettype wire

// File: verilog/hub_cfg_defines.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: byte-wide register port, 200 MHz core clock
// Notes:   included by the register bank and its descriptor reader
`ifndef HUB_CFG_DEFINES_SVH
`define HUB_CFG_DEFINES_SVH

// register offsets (byte address)
`define MFG_TEXT_BASE        8'h50
`define MFG_TEXT_LAST        8'h8f
`define PROD_TEXT_BASE       8'h90
`define PROD_TEXT_LAST       8'hcf
`define FEATURE_CFG_ADDR     8'hf0
`define MGMT_STATUS_ADDR     8'hf8
// string lengths are held at offsets of our own next to the arrays
`define MFG_LEN_ADDR         8'hd0
`define PROD_LEN_ADDR        8'hd1

// feature configuration fields
`define FEAT_SPREAD_BIT      0
`define FEAT_DELAY_LSB       1
`define FEAT_DELAY_MSB       3
`define FEAT_STATUS_EN_BIT   4
`define FEAT_RSVD_MASK       8'he0
`define FEAT_RESET           8'h00

// status and command fields
`define MGMT_CFG_ACTIVE_BIT  0
`define MGMT_SOFT_RESET_BIT  1

// string limits and descriptor indices
`define TEXT_MAX_LEN         7'h40
`define TEXT_RESET           8'h00
`define PROD_DESC_INDEX      8'h02
`define MFG_DESC_INDEX       8'h03

// power re-enable step: 200 ms at 5 ns per cycle
`define DELAY_STEP_MS        200
`define CLK_PERIOD_PS        5000
`define DELAY_STEP_CYCLES    ((`DELAY_STEP_MS * 64'd1000000000) / `CLK_PERIOD_PS)

`endif

// File: verilog/hub_cfg_pkg.sv
// Purpose: shared types for the hub configuration register bank
// Assumes: nothing beyond the defines header
// Notes:   types only; numbers live in the defines header
package hub_cfg_pkg;
    typedef logic [7:0] cfg_byte_t;
    typedef logic [6:0] text_len_t;
    typedef logic [2:0] delay_sel_t;
    typedef enum logic [2:0] {
        PWR_ON   = 3'b001,
        PWR_OFF  = 3'b010,
        PWR_WAIT = 3'b100
    } power_state_e;
endpackage

// File: verilog/hub_string_and_config_regs.sv
// Purpose: string arrays, feature config and status/command registers
// Assumes: byte-wide register port driven by the serial loader or host
// Notes:   ready pulses one cycle after a taken request
`timescale 1ns/100ps
`default_nettype none
`include "hub_cfg_defines.svh"

module hub_string_and_config_regs
    import hub_cfg_pkg::*;
#(
    parameter int     DEPTH = 64,
    parameter longint STEP_CYCLES = `DELAY_STEP_CYCLES
)
(
    // clock and reset
    input  wire logic                   CORE_CLK,
    input  wire logic                   NRST,
    // register port
    input  wire logic                   REG_WRITE,
    input  wire logic                   REG_READ,
    input  wire logic [7:0]             REG_ADDR,
    input  wire hub_cfg_pkg::cfg_byte_t REG_WDATA,
    output hub_cfg_pkg::cfg_byte_t      REG_RDATA,
    output logic                        REG_READY,
    // configuration mode indications
    input  wire logic                   SMBUS_MODE,
    input  wire logic                   CONFIG_MODE_ENTER,
    input  wire logic                   I2C_MODE_EXIT,
    // fuses and hub state
    input  wire hub_cfg_pkg::delay_sel_t FUSED_POWER_ON_DELAY,
    input  wire logic                   CHARGING_MODE_CHANGE,
    input  wire logic [3:0]             LINK_STATUS_IN,
    // descriptor request
    input  wire logic                   DESC_REQ,
    input  wire logic [7:0]             DESC_INDEX,
    output logic                        DESC_BUSY,
    output logic                        DESC_VALID,
    output hub_cfg_pkg::cfg_byte_t      DESC_DATA,
    output logic                        DESC_LAST,
    output logic                        DESC_NONE,
    // controls to the hub
    output logic [3:0]                  STATUS_OUT,
    output logic                        DOWNSTREAM_POWER_SWITCH_ENABLE,
    output logic                        PLL_SPREAD_DISABLE,
    output logic                        UPSTREAM_CONNECT_ALLOW,
    output logic                        CONFIGURATION_IN_PROGRESS
);
    // the step counter is 32 bits wide, so longer steps cannot be served
    initial
    begin
        if (DEPTH < 1 || DEPTH > 64 || STEP_CYCLES < 1
            || STEP_CYCLES > 64'h100000000)
            $error("DEPTH or STEP_CYCLES out of range");
    end

    cfg_byte_t    mfg_mem_reg [DEPTH], prod_mem_reg [DEPTH];
    text_len_t    mfg_len_reg, prod_len_reg;
    cfg_byte_t    feature_reg;
    logic         cfg_active_reg, soft_rst_reg, mode_chg_prev_reg;
    logic [2:0]   pin_meta_reg, pin_sync_reg;
    logic [3:0]   sts_meta_reg, sts_sync_reg;
    power_state_e pwr_state_reg;
    logic [31:0]  step_cnt_reg;
    delay_sel_t   steps_left_reg, delay_sel;
    logic [DEPTH*8-1:0] mfg_flat, prod_flat;
    logic         wr_mfg, wr_prod, soft_rst_req;
    logic [7:0]   mfg_off, prod_off;

    // mode pins and link status pass two flops before anything reads them
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            pin_meta_reg <= 3'h0;
            pin_sync_reg <= 3'h0;
            sts_meta_reg <= 4'h0;
            sts_sync_reg <= 4'h0;
        end
        else
        begin
            pin_meta_reg <= {SMBUS_MODE, CONFIG_MODE_ENTER, I2C_MODE_EXIT};
            pin_sync_reg <= pin_meta_reg;
            sts_meta_reg <= LINK_STATUS_IN;
            sts_sync_reg <= sts_meta_reg;
        end
    end
    wire   smbus_mode_s = pin_sync_reg[2];
    wire   enter_s      = pin_sync_reg[1];
    wire   exit_s       = pin_sync_reg[0];

    // address decode for the byte arrays
    assign mfg_off  = REG_ADDR - `MFG_TEXT_BASE;
    assign prod_off = REG_ADDR - `PROD_TEXT_BASE;
    assign wr_mfg   = REG_WRITE && REG_ADDR >= `MFG_TEXT_BASE
                      && REG_ADDR <= `MFG_TEXT_LAST && mfg_off < DEPTH;
    assign wr_prod  = REG_WRITE && REG_ADDR >= `PROD_TEXT_BASE
                      && REG_ADDR <= `PROD_TEXT_LAST && prod_off < DEPTH;
    // soft reset only while in management mode
    assign soft_rst_req = REG_WRITE && REG_ADDR == `MGMT_STATUS_ADDR
                          && REG_WDATA[`MGMT_SOFT_RESET_BIT]
                          && smbus_mode_s;

    // string arrays, flattened for the descriptor reader
    generate
        for (genvar gi = 0; gi < DEPTH; gi++)
        begin : g_text
            always_ff @(posedge CORE_CLK or negedge NRST)
            begin
                if (!NRST)
                begin
                    mfg_mem_reg[gi]  <= `TEXT_RESET;
                    prod_mem_reg[gi] <= `TEXT_RESET;
                end
                else if (soft_rst_reg)
                begin
                    mfg_mem_reg[gi]  <= `TEXT_RESET;
                    prod_mem_reg[gi] <= `TEXT_RESET;
                end
                else
                begin
                    if (wr_mfg && mfg_off[5:0] == gi)
                        mfg_mem_reg[gi] <= REG_WDATA;
                    if (wr_prod && prod_off[5:0] == gi)
                        prod_mem_reg[gi] <= REG_WDATA;
                end
            end
            assign mfg_flat[gi*8 +: 8]  = mfg_mem_reg[gi];
            assign prod_flat[gi*8 +: 8] = prod_mem_reg[gi];
        end
    endgenerate

    // lengths and feature configuration, loaded by EEPROM or host alike
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            mfg_len_reg  <= 7'h00;
            prod_len_reg <= 7'h00;
            feature_reg  <= `FEAT_RESET;
        end
        else if (soft_rst_reg)
        begin
            mfg_len_reg  <= 7'h00;
            prod_len_reg <= 7'h00;
            feature_reg  <= `FEAT_RESET;
        end
        else if (REG_WRITE)
        begin
            // over-long lengths clamp to the maximum rather than overrun
            if (REG_ADDR == `MFG_LEN_ADDR)
                mfg_len_reg <= (REG_WDATA[6:0] > `TEXT_MAX_LEN)
                               ? `TEXT_MAX_LEN : REG_WDATA[6:0];
            if (REG_ADDR == `PROD_LEN_ADDR)
                prod_len_reg <= (REG_WDATA[6:0] > `TEXT_MAX_LEN)
                                ? `TEXT_MAX_LEN : REG_WDATA[6:0];
            if (REG_ADDR == `FEATURE_CFG_ADDR)
                feature_reg <= REG_WDATA;
        end
    end

    // soft reset bit: set by a one, cleared by hardware a cycle later
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
            soft_rst_reg <= 1'b0;
        else
            soft_rst_reg <= soft_rst_req && !soft_rst_reg;
    end

    // configuration flag; entry wins over a same-cycle clear
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
            cfg_active_reg <= 1'b1;
        else if (soft_rst_reg)
            cfg_active_reg <= 1'b1;
        else if (enter_s)
            cfg_active_reg <= 1'b1;
        else if (!smbus_mode_s && exit_s)
            cfg_active_reg <= 1'b0;
        else if (REG_WRITE && REG_ADDR == `MGMT_STATUS_ADDR
                 && REG_WDATA[`MGMT_CFG_ACTIVE_BIT])
            cfg_active_reg <= 1'b0;
    end

    // read mux and one-cycle ready; unmapped offsets read zero
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            REG_RDATA <= 8'h00;
            REG_READY <= 1'b0;
        end
        else
        begin
            REG_READY <= REG_READ | REG_WRITE;
            if (REG_READ)
            begin
                if (REG_ADDR >= `MFG_TEXT_BASE && REG_ADDR <= `MFG_TEXT_LAST
                    && mfg_off < DEPTH)
                    REG_RDATA <= mfg_mem_reg[mfg_off[5:0]];
                else if (REG_ADDR >= `PROD_TEXT_BASE
                         && REG_ADDR <= `PROD_TEXT_LAST && prod_off < DEPTH)
                    REG_RDATA <= prod_mem_reg[prod_off[5:0]];
                else if (REG_ADDR == `MFG_LEN_ADDR)
                    REG_RDATA <= {1'b0, mfg_len_reg};
                else if (REG_ADDR == `PROD_LEN_ADDR)
                    REG_RDATA <= {1'b0, prod_len_reg};
                else if (REG_ADDR == `FEATURE_CFG_ADDR)
                    REG_RDATA <= feature_reg;
                else if (REG_ADDR == `MGMT_STATUS_ADDR)
                    REG_RDATA <= {6'h00, soft_rst_reg, cfg_active_reg};
                else
                    REG_RDATA <= 8'h00;
            end
        end
    end

    // fuses override the register field whenever they are nonzero
    assign delay_sel = (FUSED_POWER_ON_DELAY != 3'h0) ? FUSED_POWER_ON_DELAY
        : feature_reg[`FEAT_DELAY_MSB:`FEAT_DELAY_LSB];

    // power switch sequencing: off, then delay_sel steps of 200 ms
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            pwr_state_reg     <= PWR_ON;
            step_cnt_reg      <= 32'h0;
            steps_left_reg    <= 3'h0;
            mode_chg_prev_reg <= 1'b0;
            DOWNSTREAM_POWER_SWITCH_ENABLE <= 1'b0;
        end
        else
        begin
            mode_chg_prev_reg <= CHARGING_MODE_CHANGE;
            unique case (pwr_state_reg)
                PWR_ON:
                begin
                    DOWNSTREAM_POWER_SWITCH_ENABLE <= 1'b1;
                    if (CHARGING_MODE_CHANGE && !mode_chg_prev_reg)
                    begin
                        pwr_state_reg <= PWR_OFF;
                        DOWNSTREAM_POWER_SWITCH_ENABLE <= 1'b0;
                    end
                end
                PWR_OFF:
                begin
                    // latch the delay once so a mid-wait write cannot skew it
                    steps_left_reg <= delay_sel;
                    step_cnt_reg   <= 32'h0;
                    pwr_state_reg  <= PWR_WAIT;
                end
                PWR_WAIT:
                begin
                    if (steps_left_reg == 3'h0)
                    begin
                        pwr_state_reg <= PWR_ON;
                        DOWNSTREAM_POWER_SWITCH_ENABLE <= 1'b1;
                    end
                    else if (step_cnt_reg == 32'(STEP_CYCLES - 1))
                    begin
                        step_cnt_reg   <= 32'h0;
                        steps_left_reg <= steps_left_reg - 3'h1;
                    end
                    else
                        step_cnt_reg <= step_cnt_reg + 32'h1;
                end
            endcase
        end
    end

    // status pins, spread disable and connect gating all registered
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            STATUS_OUT                <= 4'h0;
            PLL_SPREAD_DISABLE        <= 1'b0;
            UPSTREAM_CONNECT_ALLOW    <= 1'b0;
            CONFIGURATION_IN_PROGRESS <= 1'b1;
        end
        else
        begin
            STATUS_OUT <= feature_reg[`FEAT_STATUS_EN_BIT]
                          ? sts_sync_reg : 4'h0;
            PLL_SPREAD_DISABLE <= feature_reg[`FEAT_SPREAD_BIT];
            UPSTREAM_CONNECT_ALLOW <= !cfg_active_reg;
            CONFIGURATION_IN_PROGRESS <= cfg_active_reg;
        end
    end

    // descriptor streaming
    text_descriptor_reader #(
        .DEPTH (DEPTH)
    ) u_reader (
        .clk        (CORE_CLK),
        .rst_n      (NRST),
        .req        (DESC_REQ),
        .index      (DESC_INDEX),
        .mfg_bytes  (mfg_flat),
        .prod_bytes (prod_flat),
        .mfg_len    (mfg_len_reg),
        .prod_len   (prod_len_reg),
        .busy       (DESC_BUSY),
        .valid      (DESC_VALID),
        .data       (DESC_DATA),
        .last       (DESC_LAST),
        .none       (DESC_NONE)
    );
endmodule

`default_nettype wire

// File: verilog/text_descriptor_reader.sv
// Purpose: streams one string descriptor out of the two byte arrays
// Assumes: arrays and lengths arrive as flat buses from the register bank
// Notes:   one byte per cycle, ascending offset, stops at the length
`timescale 1ns/100ps
`default_nettype none
`include "hub_cfg_defines.svh"

module text_descriptor_reader
#(
    parameter int DEPTH = 64
)
(
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               req,
    input  wire logic [7:0]         index,
    input  wire logic [DEPTH*8-1:0] mfg_bytes,
    input  wire logic [DEPTH*8-1:0] prod_bytes,
    input  wire logic [6:0]         mfg_len,
    input  wire logic [6:0]         prod_len,
    output logic                    busy,
    output logic                    valid,
    output logic [7:0]              data,
    output logic                    last,
    output logic                    none
);
    initial
    begin
        if (DEPTH < 1 || DEPTH > 64)
            $error("DEPTH must be 1..64");
    end

    logic       sel_prod_reg;
    logic [6:0] pos_reg;
    logic [6:0] len_reg;
    logic [7:0] cur_byte;

    // pick the byte at the current position of the chosen array
    always_comb
    begin
        cur_byte = sel_prod_reg ? prod_bytes[pos_reg[5:0]*8 +: 8]
                                : mfg_bytes[pos_reg[5:0]*8 +: 8];
    end

    // a zero length means no string: answer with none and send nothing
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy         <= 1'b0;
            valid        <= 1'b0;
            data         <= 8'h00;
            last         <= 1'b0;
            none         <= 1'b0;
            sel_prod_reg <= 1'b0;
            pos_reg      <= 7'h00;
            len_reg      <= 7'h00;
        end
        else
        begin
            valid <= 1'b0;
            last  <= 1'b0;
            none  <= 1'b0;
            if (!busy && req)
            begin
                if (index == `MFG_DESC_INDEX && mfg_len != 7'h00)
                begin
                    busy <= 1'b1;
                    sel_prod_reg <= 1'b0;
                    len_reg <= mfg_len;
                end
                else if (index == `PROD_DESC_INDEX && prod_len != 7'h00)
                begin
                    busy <= 1'b1;
                    sel_prod_reg <= 1'b1;
                    len_reg <= prod_len;
                end
                else
                    none <= 1'b1;
                pos_reg <= 7'h00;
            end
            else if (busy)
            begin
                valid <= 1'b1;
                data  <= cur_byte;
                pos_reg <= pos_reg + 7'h01;
                if (pos_reg + 7'h01 == len_reg)
                begin
                    last <= 1'b1;
                    busy <= 1'b0;
                end
            end
        end
    end
endmodule

`default_nettype wire
